// ===== src/dss_params.svh
// Purpose: offsets, field positions, reset values and scale figures of the status block
// Assumes: byte addressing on a 32-bit register bus
// Notes: included by the scaler and top design files of the block and by the bench
`ifndef DSS_PARAMS_SVH
`define DSS_PARAMS_SVH

// register byte offsets
`define DSS_OFS_STATUS 8'h00
`define DSS_OFS_SPEED 8'h04
`define DSS_OFS_RATED 8'h08
`define DSS_OFS_IRQ_STAT 8'h0c
`define DSS_OFS_IRQ_MASK 8'h10

// logical status word bit positions
`define DSS_BIT_RUN_CMD 1
`define DSS_BIT_FIRE 2
`define DSS_BIT_RAMP2 5
`define DSS_BIT_CFG_LOCK 6
`define DSS_BIT_ALARM 7
`define DSS_BIT_RUNNING 8
`define DSS_BIT_ENABLED 9
`define DSS_BIT_FORWARD 10
`define DSS_BIT_JOG 11
`define DSS_BIT_REMOTE 12
`define DSS_BIT_UNDERV 13
`define DSS_BIT_FAULT 15
`define DSS_RSVD_MASK 16'h4019

// interrupt event bit positions
`define DSS_EV_FAULT 0
`define DSS_EV_ALARM 1
`define DSS_EV_UNDERV 2
`define DSS_EV_REFUSE 3
`define DSS_EV_W 4

// rated frequency in tenths of a hertz, 60.0 Hz after reset
`define DSS_RATED_RST 16'h0258

// speed scale: rated frequency maps to 1 << 13 counts
`define DSS_SPEED_SHIFT 13
`define DSS_SPEED_RATED 16'h2000
`define DSS_SPEED_MAX 16'h7fff
`define DSS_SPEED_MIN 16'h8000

`endif

// ===== src/dss_pkg.sv
// Purpose: shared types of the drive status block
// Assumes: nothing beyond the params header
// Notes: constants live in dss_params.svh
package dss_pkg;
  typedef enum logic [1:0] {
    dss_okay = 2'b00,
    dss_slverr = 2'b10
  } dss_resp_e;

  typedef enum logic {
    dss_div_idle = 1'b0,
    dss_div_run = 1'b1
  } dss_div_e;
endpackage : dss_pkg

// ===== src/dss_scaler.sv
// Purpose: converts output frequency into the signed scaled speed word
// Assumes: frequency and rated setting share one unit
// Notes: restoring divider, one quotient bit per clock, runs continuously
`timescale 1ns/100ps
`include "dss_params.svh"
module dss_scaler
  import dss_pkg::*;
#(
  parameter int FREQ_W = 16
) (
  // clock and reset
  input wire logic i_clk,
  input wire logic i_rst_n,
  // operands
  input wire logic signed [FREQ_W-1:0] i_freq,
  input wire logic [FREQ_W-1:0] i_rated,
  // result
  output logic [15:0] o_speed,
  output logic o_done
);
  localparam int NUM_W = FREQ_W + `DSS_SPEED_SHIFT;
  localparam int CNT_W = $clog2(NUM_W + 1);

  dss_div_e state;
  logic [FREQ_W:0] rem;
  logic [NUM_W-1:0] quo;
  logic [FREQ_W-1:0] div_r;
  logic [CNT_W-1:0] cnt;
  logic neg;
  logic signed [FREQ_W-1:0] freq_l;

  wire [FREQ_W-1:0] abs_freq = i_freq[FREQ_W-1] ? FREQ_W'(-i_freq) : FREQ_W'(i_freq);
  wire [FREQ_W:0] shifted = {rem[FREQ_W-1:0], quo[NUM_W-1]};
  wire ge = shifted >= {1'b0, div_r};
  wire [FREQ_W:0] next_rem = ge ? shifted - {1'b0, div_r} : shifted;
  wire [NUM_W-1:0] next_quo = {quo[NUM_W-2:0], ge};
  wire last = cnt == CNT_W'(1);
  // saturate to the 16-bit two's-complement span
  wire pos_big = |next_quo[NUM_W-1:15];
  wire neg_big = (|next_quo[NUM_W-1:16]) | (next_quo[15] & (|next_quo[14:0]));
  wire [15:0] pos_val = pos_big ? `DSS_SPEED_MAX : {1'b0, next_quo[14:0]};
  wire [15:0] neg_val = neg_big ? `DSS_SPEED_MIN : 16'(-next_quo[15:0]);
  // zero rated setting would divide by zero, report standstill instead
  wire [15:0] next_speed = (div_r == '0) ? 16'h0000 : (neg ? neg_val : pos_val);

  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      state <= dss_div_idle;
      rem <= '0;
      quo <= '0;
      div_r <= '0;
      cnt <= '0;
      neg <= 1'b0;
      freq_l <= '0;
      o_speed <= 16'h0000;
      o_done <= 1'b0;
    end else begin
      o_done <= 1'b0;
      unique case (state)
        dss_div_idle: begin
          rem <= '0;
          quo <= {abs_freq, `DSS_SPEED_SHIFT'(0)};
          div_r <= i_rated;
          neg <= i_freq[FREQ_W-1];
          freq_l <= i_freq;
          cnt <= CNT_W'(NUM_W);
          state <= dss_div_run;
        end
        dss_div_run: begin
          rem <= next_rem;
          quo <= next_quo;
          cnt <= cnt - CNT_W'(1);
          if (last) begin
            o_speed <= next_speed;
            o_done <= 1'b1;
            state <= dss_div_idle;
          end
        end
      endcase
    end
  end

  default clocking @(posedge i_clk); endclocking
  default disable iff (!i_rst_n);

  zero_speed_a: assert property (o_done && freq_l == '0 |-> o_speed == 16'h0000)
    else $error("zero frequency did not give zero speed");
  rated_map_a: assert property (o_done && div_r != '0 && !neg &&
    FREQ_W'(freq_l) == div_r |-> o_speed == `DSS_SPEED_RATED)
    else $error("rated frequency did not give 8192 counts");
  full_scale_a: assert property (o_done && div_r != '0 && !neg &&
    {2'b00, div_r} <= ({2'b00, FREQ_W'(freq_l)} >> 2) |-> o_speed == `DSS_SPEED_MAX)
    else $error("four times rated frequency did not saturate");
  sign_keep_a: assert property (o_done && !neg |-> !o_speed[15])
    else $error("positive frequency gave negative speed");
  neg_sign_a: assert property (o_done && neg |-> o_speed[15] || o_speed == 16'h0000)
    else $error("negative frequency gave positive speed");
  done_pace_a: assert property ($rose(o_done) |=> !o_done [*2])
    else $error("conversion finished too soon");
endmodule : dss_scaler

// ===== src/dss_status_top.sv
// Purpose: read-only logical status word and scaled speed word over AXI4-Lite
// Assumes: drive condition inputs are synchronous levels on i_clk
// Notes: edge events of the status word raise a maskable interrupt
`timescale 1ns/100ps
`include "dss_params.svh"
module dss_status_top
  import dss_pkg::*;
#(
  parameter int ADDR_W = 8,
  parameter int FREQ_W = 16
) (
  // clock and reset
  input wire logic i_clk,
  input wire logic i_rst_n,
  // axi4-lite write address
  input wire logic i_s_axi_awvalid,
  output logic o_s_axi_awready,
  input wire logic [ADDR_W-1:0] i_s_axi_awaddr,
  input wire logic [2:0] i_s_axi_awprot,
  // axi4-lite write data
  input wire logic i_s_axi_wvalid,
  output logic o_s_axi_wready,
  input wire logic [31:0] i_s_axi_wdata,
  input wire logic [3:0] i_s_axi_wstrb,
  // axi4-lite write response
  output logic o_s_axi_bvalid,
  input wire logic i_s_axi_bready,
  output logic [1:0] o_s_axi_bresp,
  // axi4-lite read address
  input wire logic i_s_axi_arvalid,
  output logic o_s_axi_arready,
  input wire logic [ADDR_W-1:0] i_s_axi_araddr,
  input wire logic [2:0] i_s_axi_arprot,
  // axi4-lite read data
  output logic o_s_axi_rvalid,
  input wire logic i_s_axi_rready,
  output logic [31:0] o_s_axi_rdata,
  output logic [1:0] o_s_axi_rresp,
  // drive conditions
  input wire logic i_run_cmd,
  input wire logic i_fire_mode,
  input wire logic i_second_ramp,
  input wire logic i_config_lock,
  input wire logic i_alarm,
  input wire logic i_running,
  input wire logic i_enabled,
  input wire logic i_forward,
  input wire logic i_jog,
  input wire logic i_remote,
  input wire logic i_undervoltage,
  input wire logic i_fault,
  // enable gate and output frequency
  input wire logic i_enable_req,
  output logic o_drive_enable,
  input wire logic signed [FREQ_W-1:0] i_out_freq,
  // interrupt
  output logic o_irq
);
  function automatic logic is_mapped(input logic [ADDR_W-1:0] a);
    is_mapped = a == ADDR_W'(`DSS_OFS_STATUS) || a == ADDR_W'(`DSS_OFS_SPEED) ||
      a == ADDR_W'(`DSS_OFS_RATED) || a == ADDR_W'(`DSS_OFS_IRQ_STAT) ||
      a == ADDR_W'(`DSS_OFS_IRQ_MASK);
  endfunction : is_mapped

  logic [15:0] drive_logical_status;
  logic [15:0] status_word;
  logic [15:0] scaled_speed_value;
  logic [FREQ_W-1:0] motor_rated_frequency_setting;
  logic [`DSS_EV_W-1:0] irq_status;
  logic [`DSS_EV_W-1:0] irq_mask;
  logic refuse_d;
  logic aw_held;
  logic w_held;
  logic [ADDR_W-1:0] aw_addr;
  logic [31:0] w_data;
  logic [3:0] w_strb;

  // status word assembly, reserved bits read as zero
  assign status_word[0] = 1'b0;
  assign status_word[`DSS_BIT_RUN_CMD] = i_run_cmd;
  assign status_word[`DSS_BIT_FIRE] = i_fire_mode;
  assign status_word[4:3] = 2'b00;
  assign status_word[`DSS_BIT_RAMP2] = i_second_ramp;
  assign status_word[`DSS_BIT_CFG_LOCK] = i_config_lock;
  assign status_word[`DSS_BIT_ALARM] = i_alarm;
  assign status_word[`DSS_BIT_RUNNING] = i_running;
  assign status_word[`DSS_BIT_ENABLED] = i_enabled;
  assign status_word[`DSS_BIT_FORWARD] = i_forward;
  assign status_word[`DSS_BIT_JOG] = i_jog;
  assign status_word[`DSS_BIT_REMOTE] = i_remote;
  assign status_word[`DSS_BIT_UNDERV] = i_undervoltage;
  assign status_word[14] = 1'b0;
  assign status_word[`DSS_BIT_FAULT] = i_fault;

  // enabling is refused while configuration lockout stands
  wire refuse_now = i_enable_req & i_config_lock;
  wire next_enable = i_enable_req & ~i_config_lock;

  // rising edges of the reported conditions
  wire [`DSS_EV_W-1:0] events;
  assign events[`DSS_EV_FAULT] = status_word[`DSS_BIT_FAULT] &
    ~drive_logical_status[`DSS_BIT_FAULT];
  assign events[`DSS_EV_ALARM] = status_word[`DSS_BIT_ALARM] &
    ~drive_logical_status[`DSS_BIT_ALARM];
  assign events[`DSS_EV_UNDERV] = status_word[`DSS_BIT_UNDERV] &
    ~drive_logical_status[`DSS_BIT_UNDERV];
  assign events[`DSS_EV_REFUSE] = refuse_now & ~refuse_d;

  // write channel handshake and decode
  wire aw_fire = i_s_axi_awvalid & o_s_axi_awready;
  wire w_fire = i_s_axi_wvalid & o_s_axi_wready;
  wire wr_go = aw_held & w_held & ~o_s_axi_bvalid;
  wire wr_mapped = is_mapped(aw_addr);
  wire wr_rated = wr_go & (aw_addr == ADDR_W'(`DSS_OFS_RATED));
  wire wr_istat = wr_go & (aw_addr == ADDR_W'(`DSS_OFS_IRQ_STAT)) & w_strb[0];
  wire wr_imask = wr_go & (aw_addr == ADDR_W'(`DSS_OFS_IRQ_MASK)) & w_strb[0];
  wire [FREQ_W-1:0] rated_wdata = FREQ_W'({w_strb[1] ? w_data[15:8] :
    motor_rated_frequency_setting[15:8], w_strb[0] ? w_data[7:0] :
    motor_rated_frequency_setting[7:0]});
  wire [`DSS_EV_W-1:0] istat_clr = wr_istat ? w_data[`DSS_EV_W-1:0] : '0;
  // a new event wins over a clear in the same cycle
  wire [`DSS_EV_W-1:0] next_irq_status = (irq_status & ~istat_clr) | events;

  assign o_s_axi_awready = ~aw_held;
  assign o_s_axi_wready = ~w_held;

  // read channel decode
  wire ar_fire = i_s_axi_arvalid & o_s_axi_arready;
  wire rd_mapped = is_mapped(i_s_axi_araddr);
  wire [31:0] rd_word =
    (i_s_axi_araddr == ADDR_W'(`DSS_OFS_STATUS)) ? {16'h0000, drive_logical_status} :
    (i_s_axi_araddr == ADDR_W'(`DSS_OFS_SPEED)) ? {16'h0000, scaled_speed_value} :
    (i_s_axi_araddr == ADDR_W'(`DSS_OFS_RATED)) ?
      {16'h0000, 16'(motor_rated_frequency_setting)} :
    (i_s_axi_araddr == ADDR_W'(`DSS_OFS_IRQ_STAT)) ? {28'h0000000, irq_status} :
    (i_s_axi_araddr == ADDR_W'(`DSS_OFS_IRQ_MASK)) ? {28'h0000000, irq_mask} :
    32'h00000000;

  assign o_s_axi_arready = ~o_s_axi_rvalid;
  assign o_irq = |(irq_status & irq_mask);

  // status word is sampled every cycle and never written by the bus
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      drive_logical_status <= 16'h0000;
      refuse_d <= 1'b0;
      o_drive_enable <= 1'b0;
    end else begin
      drive_logical_status <= status_word;
      refuse_d <= refuse_now;
      o_drive_enable <= next_enable;
    end
  end

  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      aw_held <= 1'b0;
      aw_addr <= '0;
    end else if (aw_fire) begin
      aw_held <= 1'b1;
      aw_addr <= {i_s_axi_awaddr[ADDR_W-1:2], 2'b00};
    end else if (wr_go) begin
      aw_held <= 1'b0;
    end
  end

  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      w_held <= 1'b0;
      w_data <= 32'h00000000;
      w_strb <= 4'h0;
    end else if (w_fire) begin
      w_held <= 1'b1;
      w_data <= i_s_axi_wdata;
      w_strb <= i_s_axi_wstrb;
    end else if (wr_go) begin
      w_held <= 1'b0;
    end
  end

  // read-only words take the write and answer okay without change
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_s_axi_bvalid <= 1'b0;
      o_s_axi_bresp <= dss_okay;
    end else if (wr_go) begin
      o_s_axi_bvalid <= 1'b1;
      o_s_axi_bresp <= wr_mapped ? dss_okay : dss_slverr;
    end else if (i_s_axi_bready) begin
      o_s_axi_bvalid <= 1'b0;
    end
  end

  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      motor_rated_frequency_setting <= FREQ_W'(`DSS_RATED_RST);
      irq_mask <= '0;
      irq_status <= '0;
    end else begin
      if (wr_rated) begin
        motor_rated_frequency_setting <= rated_wdata;
      end
      if (wr_imask) begin
        irq_mask <= w_data[`DSS_EV_W-1:0];
      end
      irq_status <= next_irq_status;
    end
  end

  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_s_axi_rvalid <= 1'b0;
      o_s_axi_rdata <= 32'h00000000;
      o_s_axi_rresp <= dss_okay;
    end else if (ar_fire) begin
      o_s_axi_rvalid <= 1'b1;
      o_s_axi_rdata <= rd_word;
      o_s_axi_rresp <= rd_mapped ? dss_okay : dss_slverr;
    end else if (i_s_axi_rready) begin
      o_s_axi_rvalid <= 1'b0;
    end
  end

  // speed word scaled against the rated frequency setting
  dss_scaler #(
    .FREQ_W(FREQ_W)
  ) u_scaler (
    .i_clk(i_clk),
    .i_rst_n(i_rst_n),
    .i_freq(i_out_freq),
    .i_rated(motor_rated_frequency_setting),
    .o_speed(scaled_speed_value),
    .o_done()
  );

  default clocking @(posedge i_clk); endclocking
  default disable iff (!i_rst_n);

  status_read_a: assert property (ar_fire &&
    i_s_axi_araddr == ADDR_W'(`DSS_OFS_STATUS) |=>
    o_s_axi_rvalid && o_s_axi_rdata == {16'h0000, $past(drive_logical_status)})
    else $error("status read returned wrong word");
  run_bit_a: assert property (i_run_cmd ##1 i_run_cmd |->
    drive_logical_status[`DSS_BIT_RUN_CMD])
    else $error("run command not shown");
  fire_bit_a: assert property ($rose(i_fire_mode) |=>
    drive_logical_status[`DSS_BIT_FIRE] || !$past(i_fire_mode))
    else $error("fire override not shown");
  ramp_bit_a: assert property (!i_second_ramp |=>
    !drive_logical_status[`DSS_BIT_RAMP2])
    else $error("first ramp pair shown as second");
  cfg_refuse_a: assert property (i_config_lock |=> !o_drive_enable &&
    drive_logical_status[`DSS_BIT_CFG_LOCK])
    else $error("enable passed during configuration lockout");
  enable_pass_a: assert property (i_enable_req && !i_config_lock |=> o_drive_enable)
    else $error("enable request not passed");
  alarm_bit_a: assert property (1'b1 |=>
    drive_logical_status[`DSS_BIT_ALARM] == $past(i_alarm))
    else $error("alarm bit wrong");
  running_bit_a: assert property (i_running [*2] |->
    drive_logical_status[`DSS_BIT_RUNNING])
    else $error("running bit wrong");
  enabled_bit_a: assert property (!i_enabled |=>
    !drive_logical_status[`DSS_BIT_ENABLED])
    else $error("enabled bit wrong");
  forward_bit_a: assert property (1'b1 |=>
    drive_logical_status[`DSS_BIT_FORWARD] == $past(i_forward))
    else $error("direction bit wrong");
  jog_bit_a: assert property (i_jog |=> drive_logical_status[`DSS_BIT_JOG])
    else $error("jog bit wrong");
  remote_bit_a: assert property (1'b1 |=>
    drive_logical_status[`DSS_BIT_REMOTE] == $past(i_remote))
    else $error("remote bit wrong");
  underv_bit_a: assert property ($fell(i_undervoltage) |=>
    !drive_logical_status[`DSS_BIT_UNDERV])
    else $error("undervoltage bit wrong");
  fault_bit_a: assert property (i_fault |=> drive_logical_status[`DSS_BIT_FAULT] &&
    irq_status[`DSS_EV_FAULT] || $past(drive_logical_status[`DSS_BIT_FAULT]))
    else $error("fault not shown or not flagged");
  rsvd_zero_a: assert property ((drive_logical_status & `DSS_RSVD_MASK) == 16'h0000)
    else $error("reserved status bits not zero");
  ro_write_a: assert property (wr_go && (aw_addr == ADDR_W'(`DSS_OFS_STATUS) ||
    aw_addr == ADDR_W'(`DSS_OFS_SPEED)) |=> o_s_axi_bvalid &&
    o_s_axi_bresp == dss_okay && drive_logical_status == $past(status_word) &&
    motor_rated_frequency_setting == $past(motor_rated_frequency_setting))
    else $error("write to read-only word had an effect");
  // interrupt flags: a new event wins over a clear in the same cycle
  irq_set_a: assert property ((|events) |=>
    (irq_status & $past(events)) == $past(events))
    else $error("event flag not set");
  w1c_clear_a: assert property (wr_istat && w_data[`DSS_EV_FAULT] &&
    !events[`DSS_EV_FAULT] |=> !irq_status[`DSS_EV_FAULT])
    else $error("fault flag not cleared by write of one");
  alarm_irq_a: assert property ($rose(drive_logical_status[`DSS_BIT_ALARM]) |->
    irq_status[`DSS_EV_ALARM])
    else $error("alarm rise not flagged");
  underv_irq_a: assert property ($rose(drive_logical_status[`DSS_BIT_UNDERV]) |->
    irq_status[`DSS_EV_UNDERV])
    else $error("undervoltage rise not flagged");
  refuse_irq_a: assert property ($rose(refuse_now) |=>
    irq_status[`DSS_EV_REFUSE])
    else $error("refused enable not flagged");
  enable_drop_a: assert property (!i_enable_req |=> !o_drive_enable)
    else $error("enable without request");

  // read path and bus answers
  speed_read_a: assert property (ar_fire &&
    i_s_axi_araddr == ADDR_W'(`DSS_OFS_SPEED) |=>
    o_s_axi_rvalid && o_s_axi_rdata == {16'h0000, $past(scaled_speed_value)})
    else $error("speed read returned wrong word");
  unmapped_rd_a: assert property (ar_fire && !rd_mapped |=>
    o_s_axi_rresp == dss_slverr && o_s_axi_rdata == 32'h00000000)
    else $error("unmapped read not refused");
  rd_upper_a: assert property (o_s_axi_rvalid |-> o_s_axi_rdata[31:16] == 16'h0000)
    else $error("upper read half not zero");
  rd_hold_a: assert property (o_s_axi_rvalid && !i_s_axi_rready |=>
    o_s_axi_rvalid && $stable(o_s_axi_rdata))
    else $error("read answer dropped before taken");
  b_hold_a: assert property (o_s_axi_bvalid && !i_s_axi_bready |=>
    o_s_axi_bvalid && $stable(o_s_axi_bresp))
    else $error("write answer dropped before taken");
  rated_keep_a: assert property (!wr_rated |=>
    $stable(motor_rated_frequency_setting))
    else $error("rated setting changed without write");

  read_status_c: cover property (ar_fire && i_s_axi_araddr == ADDR_W'(`DSS_OFS_STATUS));
  write_rated_c: cover property (wr_rated ##1 o_s_axi_bvalid);
  irq_raise_c: cover property ($rose(o_irq));
  refuse_c: cover property ($rose(refuse_now) ##1 !o_drive_enable);
  enable_c: cover property ($rose(o_drive_enable));
endmodule : dss_status_top

// ===== tb/dss_drive_model.sv
// Purpose: drive environment feeding condition levels and output frequency to the block
// Assumes: commanded condition word uses the status word bit positions
// Notes: levels change just after a rising clock edge, like real drive logic
`timescale 1ns/100ps
module dss_drive_model (
  // clock
  input wire logic i_clk,
  // commanded conditions
  input wire logic [15:0] i_cond,
  input wire logic [15:0] i_freq,
  // condition levels and frequency
  output logic [11:0] o_lvl,
  output logic [15:0] o_freq
);
  initial begin
    o_lvl = 12'h000;
    o_freq = 16'h0000;
  end
  // reserved positions 0, 3, 4 and 14 have no source
  always @(posedge i_clk) begin
    o_lvl <= {i_cond[15], i_cond[13:5], i_cond[2:1]};
    o_freq <= i_freq;
  end
endmodule : dss_drive_model

// ===== tb/drive_status_speed_readout_tb.sv
// Purpose: self-checking bench of the status and speed readout block
// Assumes: register map and latencies of the block hand-over
// Notes: tables hold condition bits and speed cases with their expected words
`timescale 1ns/100ps
`include "dss_params.svh"
module drive_status_speed_readout_tb;
  import dss_pkg::*;
  logic i_clk = 1'b0;
  logic i_rst_n = 1'b0;
  logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
  logic [7:0] awaddr = 8'h00, araddr = 8'h00;
  logic [31:0] wdata = 32'h0;
  logic [15:0] cond = 16'h0, freq = 16'h0;
  logic en_req = 1'b0;
  logic awready, wready, bvalid, arready, rvalid, drive_en, irq;
  logic [1:0] bresp, rresp, resp;
  logic [31:0] rdata, val;
  logic [11:0] lvl;
  logic [15:0] mfreq;
  int failures = 0;
  int checks_done = 0;
  int cycles = 0;
  int pos [12] = '{1, 2, 5, 6, 7, 8, 9, 10, 11, 12, 13, 15};
  logic [15:0] sf [8] = '{16'h0258, 16'h0000, 16'hfed4, 16'h0960, 16'hf6a0, 16'h04af,
                          16'h012c, 16'hfed4};
  logic [15:0] se [8] = '{16'h2000, 16'h0000, 16'hf000, 16'h7fff, 16'h8000, 16'h3ff2,
                          16'h2000, 16'he000};

  always #20 i_clk = ~i_clk;

  dss_drive_model drv (.i_clk(i_clk), .i_cond(cond), .i_freq(freq), .o_lvl(lvl),
                       .o_freq(mfreq));

  dss_status_top uut (
    .i_clk(i_clk), .i_rst_n(i_rst_n),
    .i_s_axi_awvalid(awvalid), .o_s_axi_awready(awready), .i_s_axi_awaddr(awaddr),
    .i_s_axi_awprot(3'h0), .i_s_axi_wvalid(wvalid), .o_s_axi_wready(wready),
    .i_s_axi_wdata(wdata), .i_s_axi_wstrb(4'hf), .o_s_axi_bvalid(bvalid),
    .i_s_axi_bready(bready), .o_s_axi_bresp(bresp), .i_s_axi_arvalid(arvalid),
    .o_s_axi_arready(arready), .i_s_axi_araddr(araddr), .i_s_axi_arprot(3'h0),
    .o_s_axi_rvalid(rvalid), .i_s_axi_rready(rready), .o_s_axi_rdata(rdata),
    .o_s_axi_rresp(rresp), .i_run_cmd(lvl[0]), .i_fire_mode(lvl[1]),
    .i_second_ramp(lvl[2]), .i_config_lock(lvl[3]), .i_alarm(lvl[4]),
    .i_running(lvl[5]), .i_enabled(lvl[6]), .i_forward(lvl[7]), .i_jog(lvl[8]),
    .i_remote(lvl[9]), .i_undervoltage(lvl[10]), .i_fault(lvl[11]),
    .i_enable_req(en_req), .o_drive_enable(drive_en), .i_out_freq(mfreq), .o_irq(irq)
  );

  task automatic stop_test();
    $display("checks %0d failures %0d", checks_done, failures);
    if (failures == 0 && checks_done > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask : stop_test

  task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      failures++;
      $display("ERROR %s expected %h seen %h", name, exp, seen);
    end
  endtask : check

  task automatic wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
    logic aw_done;
    logic w_done;
    aw_done = 1'b0;
    w_done = 1'b0;
    @(posedge i_clk);
    awvalid <= 1'b1;
    awaddr <= a;
    wvalid <= 1'b1;
    wdata <= d;
    bready <= 1'b1;
    while (!(aw_done && w_done)) begin
      @(posedge i_clk);
      if (!aw_done && awready === 1'b1) begin
        aw_done = 1'b1;
        awvalid <= 1'b0;
      end
      if (!w_done && wready === 1'b1) begin
        w_done = 1'b1;
        wvalid <= 1'b0;
      end
    end
    do @(posedge i_clk); while (bvalid !== 1'b1);
    r = bresp;
    bready <= 1'b0;
  endtask : wr

  task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    @(posedge i_clk);
    arvalid <= 1'b1;
    araddr <= a;
    rready <= 1'b1;
    do @(posedge i_clk); while (arready !== 1'b1);
    arvalid <= 1'b0;
    do @(posedge i_clk); while (rvalid !== 1'b1);
    d = rdata;
    r = rresp;
    rready <= 1'b0;
  endtask : rd

  task automatic wrchk(input string name, input logic [7:0] a, input logic [31:0] d,
                       input logic [1:0] rexp);
    wr(a, d, resp);
    check(name, {30'h0, resp}, {30'h0, rexp});
  endtask : wrchk

  task automatic rdchk(input string name, input logic [7:0] a, input logic [31:0] exp,
                       input logic [1:0] rexp);
    rd(a, val, resp);
    check(name, val, exp);
    check({name, " resp"}, {30'h0, resp}, {30'h0, rexp});
  endtask : rdchk

  task automatic setc(input logic [15:0] c, input logic e);
    @(posedge i_clk);
    cond <= c;
    en_req <= e;
    repeat (3) @(posedge i_clk);
  endtask : setc

  always @(posedge i_clk) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      failures++;
      $display("ERROR timeout expected finish seen hang");
      stop_test();
    end
  end

  initial begin
    repeat (2) @(posedge i_clk);
    i_rst_n <= 1'b1;
    rdchk("status reset", `DSS_OFS_STATUS, 32'h0, dss_okay);
    rdchk("rated reset", `DSS_OFS_RATED, 32'h0258, dss_okay);
    rdchk("mask reset", `DSS_OFS_IRQ_MASK, 32'h0, dss_okay);
    rdchk("unmapped read", 8'h14, 32'h0, dss_slverr);
    wrchk("unmapped write", 8'h20, 32'hffff, dss_slverr);
    for (int i = 0; i < 12; i++) begin
      setc(16'h1 << pos[i], 1'b0);
      rdchk("status bit", `DSS_OFS_STATUS, 32'h1 << pos[i], dss_okay);
    end
    check("irq masked", {31'h0, irq}, 32'h0);
    setc(16'hffff, 1'b0);
    rdchk("status all", `DSS_OFS_STATUS, 32'hbfe6, dss_okay);
    wrchk("status write", `DSS_OFS_STATUS, 32'h0, dss_okay);
    wrchk("speed write", `DSS_OFS_SPEED, 32'h1234, dss_okay);
    rdchk("speed kept", `DSS_OFS_SPEED, 32'h0, dss_okay);
    rdchk("status kept", `DSS_OFS_STATUS, 32'hbfe6, dss_okay);
    setc(16'h0, 1'b0);
    wrchk("irq clear", `DSS_OFS_IRQ_STAT, 32'hf, dss_okay);
    rdchk("irq none", `DSS_OFS_IRQ_STAT, 32'h0, dss_okay);
    wrchk("mask all", `DSS_OFS_IRQ_MASK, 32'hf, dss_okay);
    setc(16'h8000, 1'b0);
    check("irq fault", {31'h0, irq}, 32'h1);
    rdchk("irq fault stat", `DSS_OFS_IRQ_STAT, 32'h1, dss_okay);
    wrchk("mask none", `DSS_OFS_IRQ_MASK, 32'h0, dss_okay);
    check("irq off", {31'h0, irq}, 32'h0);
    wrchk("irq clear1", `DSS_OFS_IRQ_STAT, 32'h1, dss_okay);
    setc(16'h0040, 1'b1);
    check("enable locked", {31'h0, drive_en}, 32'h0);
    rdchk("irq refuse", `DSS_OFS_IRQ_STAT, 32'h8, dss_okay);
    wrchk("mask refuse", `DSS_OFS_IRQ_MASK, 32'h8, dss_okay);
    check("irq refuse on", {31'h0, irq}, 32'h1);
    wrchk("irq clear8", `DSS_OFS_IRQ_STAT, 32'h8, dss_okay);
    check("irq cleared", {31'h0, irq}, 32'h0);
    setc(16'h0, 1'b1);
    check("enable free", {31'h0, drive_en}, 32'h1);
    setc(16'h0, 1'b0);
    for (int i = 0; i < 8; i++) begin
      if (i == 6) begin
        wrchk("rated write", `DSS_OFS_RATED, 32'h012c, dss_okay);
      end
      @(posedge i_clk);
      freq <= sf[i];
      repeat (75) @(posedge i_clk);
      rdchk("speed", `DSS_OFS_SPEED, {16'h0, se[i]}, dss_okay);
    end
    stop_test();
  end
endmodule : drive_status_speed_readout_tb
